// *** hdl/sfd_param_read.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfd_param_read (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire sfd_pkg::sfd_spi_in_s          spi_i,
  output var  sfd_pkg::sfd_spi_out_s         spi_o,
  input  wire logic [sfd_pkg::SFD_AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [sfd_pkg::SFD_AXI_AW-1:0] s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready
);
  import sfd_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    sfd_spi_in_s           s1;
    sfd_spi_in_s           s2;
    logic                  sck_d;
    sfd_state_e            st;
    logic [4:0]            bits;
    logic [23:0]           sh_in;
    logic [SFD_TBL_AW-1:0] addr;
    logic [7:0]            sh_out;
    sfd_spi_out_s          spo;
    logic                  busy;
    logic                  aw_h;
    logic                  w_h;
    logic [SFD_AXI_AW-1:0] awaddr;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } sfd_regs_s;

  sfd_regs_s  r_reg;
  sfd_regs_s  r_next;
  logic       rise;
  logic       fall;
  logic [7:0] opc;
  logic [7:0] byte_out;
  logic [7:0] tbl_byte;
  sfd_ctrl_s  ctrl_v;
  sfd_stat_s  stat_v;

  // Edges found on the second sync stage only
  assign rise = r_reg.s2.sck & ~r_reg.sck_d;
  assign fall = ~r_reg.s2.sck & r_reg.sck_d;
  assign opc  = {r_reg.sh_in[6:0], r_reg.s2.sdi};

  assign spi_o         = r_reg.spo;
  assign s_axi_awready = ~r_reg.aw_h & ~r_reg.bvalid;
  assign s_axi_wready  = ~r_reg.w_h & ~r_reg.bvalid;
  assign s_axi_bvalid  = r_reg.bvalid;
  assign s_axi_bresp   = r_reg.bresp;
  assign s_axi_arready = ~r_reg.rvalid;
  assign s_axi_rvalid  = r_reg.rvalid;
  assign s_axi_rdata   = r_reg.rdata;
  assign s_axi_rresp   = r_reg.rresp;

  // ==========================================================
  // Next state
  always_comb begin
    r_next   = r_reg;
    byte_out = r_reg.sh_out;
    ctrl_v   = '0;
    stat_v   = '0;
    r_next.s1    = spi_i;
    r_next.s2    = r_reg.s1;
    r_next.sck_d = r_reg.s2.sck;

    if (r_reg.s2.cs_n) begin
      // Deselect ends everything, even mid-byte
      r_next.st   = SFD_ST_IDLE;
      r_next.bits = '0;
      r_next.spo  = '0;
    end else begin
      case (r_reg.st)
        SFD_ST_IDLE: begin
          r_next.st   = SFD_ST_CMD;
          r_next.bits = '0;
        end
        SFD_ST_CMD: begin
          if (rise) begin
            r_next.sh_in = {r_reg.sh_in[22:0], r_reg.s2.sdi};
            r_next.bits  = r_reg.bits + 5'h01;
            if (r_reg.bits == SFD_CMD_LAST) begin
              r_next.bits = '0;
              // Busy write cycle: drop the command, leave the cycle alone
              if (r_reg.busy || opc != SFD_OPC_READ) begin
                r_next.st = SFD_ST_IGN;
              end else begin
                r_next.st = SFD_ST_ADDR;
              end
            end
          end
        end
        SFD_ST_ADDR: begin
          if (rise) begin
            r_next.sh_in = {r_reg.sh_in[22:0], r_reg.s2.sdi};
            r_next.bits  = r_reg.bits + 5'h01;
            if (r_reg.bits == SFD_ADDR_LAST) begin
              r_next.bits = '0;
              r_next.st   = SFD_ST_DUMMY;
              // Upper address bits alias onto the table space
              r_next.addr = opc[SFD_TBL_AW-1:0];
            end
          end
        end
        SFD_ST_DUMMY: begin
          if (rise) begin
            r_next.bits = r_reg.bits + 5'h01;
            if (r_reg.bits == SFD_DUMMY_LAST) begin
              r_next.bits = '0;
              r_next.st   = SFD_ST_DATA;
            end
          end
        end
        SFD_ST_DATA: begin
          if (fall) begin
            if (r_reg.bits == '0) begin
              byte_out = sfd_table(r_reg.addr);
            end
            r_next.spo.sdo    = byte_out[7];
            r_next.spo.sdo_oe = 1'b1;
            r_next.sh_out     = {byte_out[6:0], 1'b0};
            r_next.bits       = r_reg.bits + 5'h01;
            if (r_reg.bits == SFD_BYTE_LAST) begin
              r_next.bits = '0;
              // Counter width makes the top address roll to zero
              r_next.addr = r_reg.addr + 1'b1;
            end
          end
        end
        SFD_ST_IGN: begin
          r_next.st = SFD_ST_IGN;
        end
        default: begin
          r_next.st = SFD_ST_IDLE;
        end
      endcase
    end

    // AXI4-Lite write: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      r_next.aw_h   = 1'b1;
      r_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      r_next.w_h   = 1'b1;
      r_next.wdata = s_axi_wdata;
      r_next.wstrb = s_axi_wstrb;
    end
    if (r_reg.aw_h && r_reg.w_h) begin
      r_next.aw_h   = 1'b0;
      r_next.w_h    = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp  = SFD_RESP_OKAY;
      if (r_reg.awaddr == SFD_REG_CTRL) begin
        if (r_reg.wstrb[0]) begin
          ctrl_v      = sfd_ctrl_s'(r_reg.wdata);
          r_next.busy = ctrl_v.busy;
        end
      end else if (r_reg.awaddr != SFD_REG_STAT) begin
        r_next.bresp = SFD_RESP_SLVERR;
      end
    end
    if (r_reg.bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end

    // AXI4-Lite read
    if (s_axi_arvalid && s_axi_arready) begin
      r_next.rvalid = 1'b1;
      r_next.rresp  = SFD_RESP_OKAY;
      // Fresh word: a write landing this cycle must not leak into the read
      ctrl_v        = '0;
      ctrl_v.busy   = r_reg.busy;
      stat_v.addr   = r_reg.addr;
      stat_v.st     = r_reg.st;
      case (s_axi_araddr)
        SFD_REG_CTRL: r_next.rdata = ctrl_v;
        SFD_REG_STAT: r_next.rdata = stat_v;
        default: begin
          r_next.rdata = '0;
          r_next.rresp = SFD_RESP_SLVERR;
        end
      endcase
    end
    if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  assign tbl_byte = sfd_table(r_reg.addr);

  property p_opcode;
    (r_reg.st == SFD_ST_ADDR && $past(r_reg.st) == SFD_ST_CMD) |-> r_reg.sh_in[7:0] == SFD_OPC_READ;
  endproperty
  a_opcode: assert property (p_opcode) else $error("address phase without read opcode");

  property p_sample;
    (rise && (r_reg.st == SFD_ST_CMD || r_reg.st == SFD_ST_ADDR) && !r_reg.s2.cs_n)
      |=> r_reg.sh_in[0] == $past(r_reg.s2.sdi);
  endproperty
  a_sample: assert property (p_sample) else $error("input bit not sampled on rise");

  property p_sdo_fall;
    (r_reg.spo.sdo_oe && $changed(r_reg.spo.sdo)) |-> $past(fall);
  endproperty
  a_sdo_fall: assert property (p_sdo_fall) else $error("output changed off a falling edge");

  property p_start;
    (r_reg.st == SFD_ST_DATA && $past(r_reg.st) == SFD_ST_DUMMY) |-> r_reg.addr == r_reg.sh_in[7:0];
  endproperty
  a_start: assert property (p_start) else $error("output not at supplied address");

  property p_incr;
    (r_reg.st == SFD_ST_DATA && fall && r_reg.bits == SFD_BYTE_LAST && !r_reg.s2.cs_n)
      |=> r_reg.addr == $past(r_reg.addr) + 8'h01;
  endproperty
  a_incr: assert property (p_incr) else $error("address did not advance or wrap");

  property p_stop;
    r_reg.s2.cs_n |=> !r_reg.spo.sdo_oe && r_reg.st == SFD_ST_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("transfer kept going after deselect");

  property p_busy;
    (r_reg.st == SFD_ST_CMD && rise && r_reg.bits == SFD_CMD_LAST && r_reg.busy && !r_reg.s2.cs_n)
      |=> r_reg.st == SFD_ST_IGN;
  endproperty
  a_busy: assert property (p_busy) else $error("command accepted while busy");

  property p_first_bit;
    (r_reg.st == SFD_ST_DATA && fall && r_reg.bits == 5'h00 && !r_reg.s2.cs_n)
      |=> r_reg.spo.sdo == $past(tbl_byte[7]) && r_reg.spo.sdo_oe;
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("byte not sent msb first");

  property p_oe_data;
    r_reg.spo.sdo_oe |-> r_reg.st == SFD_ST_DATA;
  endproperty
  a_oe_data: assert property (p_oe_data) else $error("output driven outside data phase");

  c_read:   cover property (r_reg.st == SFD_ST_DUMMY ##1 r_reg.st == SFD_ST_DATA);
  c_reject: cover property (r_reg.busy && r_reg.st == SFD_ST_IGN);
  c_wrap:   cover property (r_reg.st == SFD_ST_DATA && r_reg.addr == 8'hFF ##1 r_reg.addr == 8'h00);
  c_abort:  cover property (r_reg.st == SFD_ST_DATA && r_reg.bits != 5'h00 && r_reg.s2.cs_n);

endmodule
`default_nettype wire

// *** hdl/sfd_pkg.sv ***
// What this block does
// - Select low, opcode 5Ah, 3-byte address, dummy.
// - Sample command, address, dummy on clock rise.
// - After dummy, shift table bytes on falls.
// - Output starts at the low 8 bits of the supplied address.
// - Address advances by one after each byte.
// - Past highest address, wrap to zero, continue.
// - Select high stops the transfer at once.
// - Command ignored while a write cycle busy.
// - Bytes 00h-03h hold the 53h 46h 44h 50h signature.
// - Byte 04h minor 00h, byte 05h major 01h.
// - Byte 06h header count 00h, 07h FFh.
// - Header id 00h, table revision 00h, 01h.
// - Byte 0Bh table length 09h words.
// - Pointer 000030h low byte first, 0Fh FFh.
// - Byte 30h: 4KB erase 01b, write granularity 1b.
// - Byte 30h bits 4:3 00b, 7:5 111b.
// - Byte 31h returns 4KB erase opcode 20h.
// - Table bit 16 set: 1-1-2 read supported.
// - Table bits 18:17 read 00b, 3-byte addressing.
// - Bit 19 clear, bits 20-22 set.
package sfd_pkg;

  // ==========================================================
  // Serial command framing
  localparam logic [7:0] SFD_OPC_READ    = 8'h5A;
  localparam logic [4:0] SFD_CMD_LAST    = 5'h07;
  localparam logic [4:0] SFD_ADDR_LAST   = 5'h17;
  localparam logic [4:0] SFD_DUMMY_LAST  = 5'h07;
  localparam logic [4:0] SFD_BYTE_LAST   = 5'h07;
  localparam int         SFD_TBL_AW      = 8;

  // ==========================================================
  // Parameter table contents
  localparam logic [7:0] SFD_SIG_B0      = 8'h53;
  localparam logic [7:0] SFD_SIG_B1      = 8'h46;
  localparam logic [7:0] SFD_SIG_B2      = 8'h44;
  localparam logic [7:0] SFD_SIG_B3      = 8'h50;
  localparam logic [7:0] SFD_REV_MINOR   = 8'h00;
  localparam logic [7:0] SFD_REV_MAJOR   = 8'h01;
  localparam logic [7:0] SFD_HDR_COUNT   = 8'h00;
  localparam logic [7:0] SFD_HDR_ID      = 8'h00;
  localparam logic [7:0] SFD_TBL_LEN     = 8'h09;
  localparam logic [7:0] SFD_TBL_PTR_B0  = 8'h30;
  localparam logic [7:0] SFD_TBL_PTR_B12 = 8'h00;
  localparam logic [7:0] SFD_RSVD_BYTE   = 8'hFF;
  // {rsvd 111b, wren 00b, write gran 1b, erase 01b}
  localparam logic [7:0] SFD_BPT_B0      = 8'hE5;
  localparam logic [7:0] SFD_BPT_ERASE4K = 8'h20;
  // {rsvd 1b, 1-1-4, 1-4-4, 1-2-2, no dtr, addr 00b, 1-1-2}
  localparam logic [7:0] SFD_BPT_B2      = 8'hF1;

  // ==========================================================
  // Register map, AXI4-Lite
  localparam int         SFD_AXI_AW      = 8;
  localparam logic [7:0] SFD_REG_CTRL    = 8'h00;
  localparam logic [7:0] SFD_REG_STAT    = 8'h04;
  localparam logic [1:0] SFD_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SFD_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SFD_ST_IDLE  = 3'h0,
    SFD_ST_CMD   = 3'h1,
    SFD_ST_ADDR  = 3'h3,
    SFD_ST_DUMMY = 3'h2,
    SFD_ST_DATA  = 3'h6,
    SFD_ST_IGN   = 3'h4
  } sfd_state_e;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic sdi;
  } sfd_spi_in_s;

  typedef struct packed {
    logic sdo;
    logic sdo_oe;
  } sfd_spi_out_s;

  typedef struct packed {
    logic [30:0] rsvd;
    logic        busy;
  } sfd_ctrl_s;

  typedef struct packed {
    logic [15:0]           rsvd_hi;
    logic [SFD_TBL_AW-1:0] addr;
    logic [4:0]            rsvd_lo;
    sfd_state_e            st;
  } sfd_stat_s;

  function automatic logic [7:0] sfd_table(input logic [SFD_TBL_AW-1:0] a);
    case (a)
      8'h00:   sfd_table = SFD_SIG_B0;
      8'h01:   sfd_table = SFD_SIG_B1;
      8'h02:   sfd_table = SFD_SIG_B2;
      8'h03:   sfd_table = SFD_SIG_B3;
      8'h04:   sfd_table = SFD_REV_MINOR;
      8'h05:   sfd_table = SFD_REV_MAJOR;
      8'h06:   sfd_table = SFD_HDR_COUNT;
      8'h08:   sfd_table = SFD_HDR_ID;
      8'h09:   sfd_table = SFD_REV_MINOR;
      8'h0A:   sfd_table = SFD_REV_MAJOR;
      8'h0B:   sfd_table = SFD_TBL_LEN;
      8'h0C:   sfd_table = SFD_TBL_PTR_B0;
      8'h0D:   sfd_table = SFD_TBL_PTR_B12;
      8'h0E:   sfd_table = SFD_TBL_PTR_B12;
      8'h30:   sfd_table = SFD_BPT_B0;
      8'h31:   sfd_table = SFD_BPT_ERASE4K;
      8'h32:   sfd_table = SFD_BPT_B2;
      default: sfd_table = SFD_RSVD_BYTE;
    endcase
  endfunction

endpackage

// *** tb/sfd_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfd_host_model (
  input  wire logic                  aclk,
  output var  sfd_pkg::sfd_spi_in_s  spi_i,
  input  wire sfd_pkg::sfd_spi_out_s spi_o
);
  import sfd_pkg::*;
  logic [7:0] got[$];
  logic       oe_seen;

  initial begin
    spi_i   = 3'b100;
    oe_seen = 1'b0;
  end

  always @(posedge aclk) begin
    if (!spi_i.cs_n && spi_o.sdo_oe) oe_seen = 1'b1;
  end

  // ==========================================================
  // Link clock: half period of 10 aclk gives 80 ns, a 160 ns cycle
  task automatic half();
    repeat (10) @(posedge aclk);
  endtask

  // ==========================================================
  // One framed transfer; sck idles low outside frames
  task automatic frame(input logic [7:0] op, input logic [23:0] addr, input int nbits);
    logic [39:0] hdr;
    logic [7:0]  sh;
    hdr = {op, addr, 8'h00};
    sh = 8'h00;
    got.delete();
    oe_seen = 1'b0;
    @(posedge aclk);
    spi_i.cs_n <= 1'b0;
    half();
    for (int i = 0; i < 40; i++) begin
      spi_i.sdi <= hdr[39-i];
      half();
      spi_i.sck <= 1'b1;
      half();
      spi_i.sck <= 1'b0;
    end
    for (int i = 0; i < nbits; i++) begin
      half();
      spi_i.sck <= 1'b1;
      // Undriven line shows the inverse of its last level
      sh = {sh[6:0], spi_o.sdo_oe ? spi_o.sdo : ~spi_o.sdo};
      if (i % 8 == 7) got.push_back(sh);
      half();
      spi_i.sck <= 1'b0;
    end
    half();
    spi_i.cs_n <= 1'b1;
    spi_i.sdi  <= ~spi_i.sdi;
    half();
  endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sfd_pkg::*;
  logic         aclk, aresetn;
  sfd_spi_in_s  spi_i;
  sfd_spi_out_s spi_o;
  logic [7:0]   awaddr, araddr;
  logic [31:0]  wdata, rdata;
  logic [3:0]   wstrb;
  logic [1:0]   bresp, rresp;
  logic         awvalid, wvalid, bready, arvalid, rready;
  logic         awready, wready, bvalid, arready, rvalid;
  int           failures, checked, cyc;
  logic [7:0]   starts[4] = '{8'h00, 8'h30, 8'hFE, 8'h07};
  int           lens[4]   = '{16, 3, 4, 2};

  sfd_param_read uut (
    .aclk(aclk), .aresetn(aresetn), .spi_i(spi_i), .spi_o(spi_o),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  sfd_host_model host (.aclk(aclk), .spi_i(spi_i), .spi_o(spi_o));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // ==========================================================
  // Expected table contents
  function automatic logic [7:0] exp_byte(input logic [7:0] a);
    case (a)
      8'h00: return 8'h53;
      8'h01: return 8'h46;
      8'h02: return 8'h44;
      8'h03: return 8'h50;
      8'h05, 8'h0A: return 8'h01;
      8'h0B: return 8'h09;
      8'h0C: return 8'h30;
      8'h04, 8'h06, 8'h08, 8'h09, 8'h0D, 8'h0E: return 8'h00;
      8'h30: return 8'hE5;
      8'h31: return 8'h20;
      8'h32: return 8'hF1;
      default: return 8'hFF;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // Register bus master; waits only on the slave's handshakes
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hF; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      stop_test();
    end
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  a;
    int          n;
    failures = 0; checked = 0; aresetn = 1'b0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    d = $urandom(32'h802f3c70);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(spi_o.sdo_oe, 1'b0);
    repeat (10) @(posedge aclk);
    // ========================================================
    // Corner starts first, then random starts and lengths
    for (int i = 0; i < 10; i++) begin
      a = (i < 4) ? starts[i] : 8'($urandom);
      n = (i < 4) ? lens[i] : 1 + $urandom % 4;
      host.frame(SFD_OPC_READ, {16'h0000, a}, n * 8);
      chk(host.oe_seen, 1'b1);
      for (int k = 0; k < n; k++) chk(host.got[k], exp_byte(8'(a + k)));
    end
    // ========================================================
    // Busy blocks the read but busy itself stays set
    axi_wr(SFD_REG_CTRL, 32'h1, r);
    chk(r, SFD_RESP_OKAY);
    host.frame(SFD_OPC_READ, 24'h000000, 16);
    chk(host.oe_seen, 1'b0);
    axi_rd(SFD_REG_CTRL, d, r);
    chk(d[0], 1'b1);
    axi_wr(SFD_REG_CTRL, 32'h0, r);
    host.frame(8'hA5, 24'h000000, 16);
    chk(host.oe_seen, 1'b0);
    // ========================================================
    // Abort inside a byte, then a fresh frame right after
    host.frame(SFD_OPC_READ, 24'h000004, 11);
    chk(host.got[0], 8'h00);
    chk(spi_o.sdo_oe, 1'b0);
    host.frame(SFD_OPC_READ, 24'h000002, 16);
    chk(host.got[0], 8'h44);
    chk(host.got[1], 8'h50);
    // ========================================================
    // Register map edges
    axi_rd(8'h10, d, r);
    chk(r, SFD_RESP_SLVERR);
    chk(d, 32'h0);
    axi_wr(8'h10, 32'h1, r);
    chk(r, SFD_RESP_SLVERR);
    axi_wr(SFD_REG_STAT, 32'hFFFF_FFFF, r);
    chk(r, SFD_RESP_OKAY);
    axi_rd(SFD_REG_STAT, d, r);
    chk(d[2:0], SFD_ST_IDLE);
    chk(d[15:8], 8'h04);
    axi_rd(SFD_REG_CTRL, d, r);
    chk(d, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
